// [logic/slc_pkg.sv]
// Purpose: Shared constants and types for the serial link config register block
// Assumes: AXI4-Lite with 32-bit data, byte addresses
// Notes: Cycle timer geometry and register map live here
package slc_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] CYCLE_TIMER_OFS = 8'h14;
  localparam logic [7:0] ISO_RX_SEL_OFS = 8'h18;
  localparam logic [7:0] QUEUE_CTRL_OFS = 8'h1c;
  localparam logic [7:0] DIAG_CTRL_OFS = 8'h20;
  localparam logic [7:0] LINK_CTRL_OFS = 8'h00;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h04;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h08;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int SEC_LSB = 0;
  localparam int CYC_LSB = 7;
  localparam int OFS_LSB = 20;
  localparam int LABEL_A_LSB = 0;
  localparam int CHAN_A_LSB = 2;
  localparam int LABEL_B_LSB = 8;
  localparam int CHAN_B_LSB = 10;
  localparam int LABEL_CMP_BIT = 31;
  localparam int FLUSH_ATX_BIT = 0;
  localparam int FLUSH_ITX_BIT = 1;
  localparam int FLUSH_RX_BIT = 2;
  localparam int TRIG_LSB = 5;
  localparam int ATX_ALLOC_LSB = 14;
  localparam int ITX_ALLOC_LSB = 23;
  localparam int SNOOP_BIT = 0;
  localparam int OVERRIDE_BIT = 4;
  // Link control bits (own register)
  localparam int CTL_TIMER_EN_BIT = 0;
  localparam int CTL_MASTER_BIT = 1;
  localparam int CTL_EXT_SRC_BIT = 2;
  localparam int CTL_ACCEPT_ALL_BIT = 3;
  localparam int CTL_SPLIT_EN_BIT = 4;
  localparam int CTL_FLUSH_BAD_BIT = 5;
  localparam int CTL_PORT_A_EN_BIT = 6;
  localparam int CTL_PORT_B_EN_BIT = 7;
  // Interrupt status bits
  localparam int IRQ_SEC_BIT = 0;
  localparam int IRQ_BLOCK_BIT = 1;
  localparam int IRQ_W = 2;

  // ****************************************
  // Counts
  // ****************************************
  localparam logic [11:0] OFFSET_WRAP = 12'd3071;
  localparam logic [12:0] CYCLE_WRAP = 13'd7999;
  localparam logic [6:0] SECOND_WRAP = 7'd127;
  localparam logic [9:0] QUEUE_TOTAL = 10'd512;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    SLC_WR_IDLE = 2'b00,
    SLC_WR_RESP = 2'b01
  } slc_wr_state_t;

  typedef struct packed {
    logic valid;
    logic [5:0] channel;
    logic [1:0] label;
    logic last;
    logic [31:0] data;
  } slc_rx_word_t;

  typedef struct packed {
    logic valid;
    logic is_token;
    logic snoop;
    logic [31:0] data;
  } slc_queue_word_t;

  typedef struct packed {
    logic flush_async_tx_queue;
    logic flush_iso_tx_queue;
    logic flush_rx_queue;
    logic [8:0] async_tx_alloc;
    logic [8:0] iso_tx_alloc;
    logic [9:0] rx_alloc;
  } slc_queue_cmd_t;
endpackage

// [logic/slc_regs.sv]
// Contract
// - Cycle timer holds seconds, cycles, offset fields
// - Control bits govern counting and loading
// - Accept-all ignores channel select register
// - Port A enable accepts matching channel
// - Port B enable accepts matching channel
// - Label compare needs label and channel
// - Queue flush bits empty queues, self-clear
// - Receive queue gets remainder of 512
// - Split packets into trigger-size blocks with tokens
// - One block-ready interrupt per block
// - Split off when disabled or flushing bad
// - Snoop captures every bus packet
// - Override makes read-only bits writable
// - Diagnostic bits other than snoop and override read-only without override
// - Seconds advance sets second tick flag
//
// Purpose: Config registers, cycle timer and receive block splitter of a serial link
// Assumes: AXI4-Lite slave; receive words arrive one per cycle from the link core
// Notes: Partial writes to the cycle timer are refused with SLVERR
`timescale 1ns/1ps
module slc_regs (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cycle_tick,
  input wire logic [31:0] cycle_load_value,
  input wire logic cycle_load,
  input wire slc_pkg::slc_rx_word_t rx_word,
  output slc_pkg::slc_queue_word_t rx_queue_word,
  output slc_pkg::slc_queue_cmd_t queue_cmd,
  output logic snoop_capture_en,
  output logic irq
);
  import slc_pkg::*;

  // Each token takes an extra output slot, so payload queues behind it;
  // a packet with more back-to-back blocks than this loses words
  localparam int PEND_DEPTH = 6;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [31:0] cycle_timer;
    logic [31:0] iso_rx_sel;
    logic [31:0] queue_ctrl;
    logic [31:0] diag_ctrl;
    logic [31:0] link_ctrl;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    slc_wr_state_t wr_state;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [8:0] blk_count;
    slc_queue_word_t [PEND_DEPTH-1:0] pend_q;
    logic [2:0] pend_cnt;
    logic in_packet;
    slc_queue_word_t out_word;
  } slc_state_t;

  slc_state_t state_reg;
  slc_state_t state_next;

  function automatic logic [31:0] merge_word(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic chan_match(input logic [31:0] sel, input int chan_lsb, input int label_lsb,
                                      input slc_rx_word_t w);
    logic hit;
    hit = (w.channel == sel[chan_lsb +: 6]);
    if (sel[LABEL_CMP_BIT]) begin
      hit = hit && (w.label == sel[label_lsb +: 2]);
    end
    return hit;
  endfunction

  logic wr_fire;
  logic wr_ok;
  logic sec_advance;
  logic accept;
  logic split_en;
  logic [8:0] trig_size;
  logic [31:0] rd_value;
  logic rd_hit;

  assign wr_fire = s_axi_awvalid && s_axi_wvalid && (state_reg.wr_state == SLC_WR_IDLE);
  assign s_axi_awready = wr_fire;
  assign s_axi_wready = wr_fire;
  assign s_axi_arready = !state_reg.rvalid;
  assign s_axi_bvalid = (state_reg.wr_state == SLC_WR_RESP);
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rdata = state_reg.rdata;
  assign s_axi_rresp = state_reg.rresp;
  assign trig_size = state_reg.queue_ctrl[TRIG_LSB +: 9];
  assign split_en = state_reg.link_ctrl[CTL_SPLIT_EN_BIT] && !state_reg.link_ctrl[CTL_FLUSH_BAD_BIT]
                    && (trig_size != 9'd0);
  assign snoop_capture_en = state_reg.diag_ctrl[SNOOP_BIT];
  assign rx_queue_word = state_reg.out_word;
  assign irq = |(state_reg.irq_status & state_reg.irq_mask);

  always_comb begin
    queue_cmd.flush_async_tx_queue = state_reg.queue_ctrl[FLUSH_ATX_BIT];
    queue_cmd.flush_iso_tx_queue = state_reg.queue_ctrl[FLUSH_ITX_BIT];
    queue_cmd.flush_rx_queue = state_reg.queue_ctrl[FLUSH_RX_BIT];
    queue_cmd.async_tx_alloc = state_reg.queue_ctrl[ATX_ALLOC_LSB +: 9];
    queue_cmd.iso_tx_alloc = state_reg.queue_ctrl[ITX_ALLOC_LSB +: 9];
    // Wraps if the host breaks its allocation limits; not guarded in hardware
    queue_cmd.rx_alloc = QUEUE_TOTAL - {1'b0, queue_cmd.async_tx_alloc}
                         - {1'b0, queue_cmd.iso_tx_alloc};
  end

  always_comb begin
    accept = state_reg.link_ctrl[CTL_ACCEPT_ALL_BIT];
    accept = accept || snoop_capture_en;
    // Port enables live in the link control register
    if (state_reg.link_ctrl[CTL_PORT_A_EN_BIT]
        && chan_match(state_reg.iso_rx_sel, CHAN_A_LSB, LABEL_A_LSB, rx_word)) begin
      accept = 1'b1;
    end
    if (state_reg.link_ctrl[CTL_PORT_B_EN_BIT]
        && chan_match(state_reg.iso_rx_sel, CHAN_B_LSB, LABEL_B_LSB, rx_word)) begin
      accept = 1'b1;
    end
  end

  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      CYCLE_TIMER_OFS: rd_value = state_reg.cycle_timer;
      ISO_RX_SEL_OFS: rd_value = state_reg.iso_rx_sel;
      QUEUE_CTRL_OFS: rd_value = state_reg.queue_ctrl;
      DIAG_CTRL_OFS: rd_value = state_reg.diag_ctrl;
      LINK_CTRL_OFS: rd_value = state_reg.link_ctrl;
      IRQ_STATUS_OFS: rd_value = {{(32-IRQ_W){1'b0}}, state_reg.irq_status};
      IRQ_MASK_OFS: rd_value = {{(32-IRQ_W){1'b0}}, state_reg.irq_mask};
      default: begin
        rd_value = REG_RESET;
        rd_hit = 1'b0;
      end
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;
    logic ro_ok;
    slc_queue_word_t [PEND_DEPTH+1:0] line;
    logic [3:0] n;
    state_next = state_reg;
    irq_set = '0;
    irq_clr = '0;
    line = '0;
    n = 4'd0;
    sec_advance = 1'b0;
    wr_ok = 1'b1;
    ro_ok = state_reg.diag_ctrl[OVERRIDE_BIT];
    state_next.out_word = '0;
    // Flush strobes last one cycle
    state_next.queue_ctrl[FLUSH_RX_BIT:FLUSH_ATX_BIT] = 3'b000;

    // Cycle timer
    if (state_reg.link_ctrl[CTL_TIMER_EN_BIT]) begin
      if (!state_reg.link_ctrl[CTL_MASTER_BIT] && cycle_load) begin
        state_next.cycle_timer = cycle_load_value;
      end else if (!state_reg.link_ctrl[CTL_EXT_SRC_BIT] || cycle_tick) begin
        if (state_reg.cycle_timer[OFS_LSB +: 12] == OFFSET_WRAP) begin
          state_next.cycle_timer[OFS_LSB +: 12] = 12'h000;
          if (state_reg.cycle_timer[CYC_LSB +: 13] == CYCLE_WRAP) begin
            state_next.cycle_timer[CYC_LSB +: 13] = 13'h0000;
            state_next.cycle_timer[SEC_LSB +: 7] = state_reg.cycle_timer[SEC_LSB +: 7] + 7'd1;
            sec_advance = 1'b1;
          end else begin
            state_next.cycle_timer[CYC_LSB +: 13] = state_reg.cycle_timer[CYC_LSB +: 13] + 13'd1;
          end
        end else begin
          state_next.cycle_timer[OFS_LSB +: 12] = state_reg.cycle_timer[OFS_LSB +: 12] + 12'd1;
        end
      end
    end
    irq_set[IRQ_SEC_BIT] = sec_advance;

    // Receive splitter: pending words, then a token, then the new word, one out per cycle
    for (int i = 0; i < PEND_DEPTH; i++) begin
      line[i] = state_reg.pend_q[i];
    end
    n = {1'b0, state_reg.pend_cnt};
    if (rx_word.valid && (accept || state_reg.in_packet)) begin
      state_next.in_packet = !rx_word.last;
      if (split_en) begin
        if (state_reg.blk_count == 9'd0) begin
          line[n] = '{valid: 1'b1, is_token: 1'b1, snoop: snoop_capture_en,
                      data: {23'h00_0000, (rx_word.last ? 9'd1 : trig_size)}};
          n = n + 4'd1;
        end
        state_next.blk_count = state_reg.blk_count + 9'd1;
        if ((state_reg.blk_count + 9'd1 == trig_size) || rx_word.last) begin
          state_next.blk_count = 9'd0;
          irq_set[IRQ_BLOCK_BIT] = 1'b1;
        end
      end else if (rx_word.last) begin
        irq_set[IRQ_BLOCK_BIT] = 1'b1;
      end
      line[n] = '{valid: 1'b1, is_token: 1'b0, snoop: snoop_capture_en, data: rx_word.data};
      n = n + 4'd1;
    end
    state_next.out_word = line[0];
    for (int i = 0; i < PEND_DEPTH; i++) begin
      state_next.pend_q[i] = line[i + 1];
    end
    if (n == 4'd0) begin
      state_next.pend_cnt = 3'd0;
    end else if (n > 4'(PEND_DEPTH)) begin
      state_next.pend_cnt = 3'(PEND_DEPTH);
    end else begin
      state_next.pend_cnt = 3'(n - 4'd1);
    end

    // Register writes
    if (wr_fire) begin
      case (s_axi_awaddr)
        CYCLE_TIMER_OFS: begin
          if (s_axi_wstrb == 4'hf) begin
            state_next.cycle_timer = s_axi_wdata;
          end else begin
            wr_ok = 1'b0;
          end
        end
        ISO_RX_SEL_OFS: state_next.iso_rx_sel = merge_word(state_reg.iso_rx_sel, s_axi_wdata, s_axi_wstrb);
        QUEUE_CTRL_OFS: state_next.queue_ctrl = merge_word(state_reg.queue_ctrl, s_axi_wdata, s_axi_wstrb);
        DIAG_CTRL_OFS: begin
          state_next.diag_ctrl = merge_word(state_reg.diag_ctrl, s_axi_wdata, s_axi_wstrb);
          if (!ro_ok && !(s_axi_wstrb[0] && s_axi_wdata[OVERRIDE_BIT])) begin
            state_next.diag_ctrl = {state_reg.diag_ctrl[31:5], state_next.diag_ctrl[OVERRIDE_BIT],
                                    state_reg.diag_ctrl[3:1], state_next.diag_ctrl[SNOOP_BIT]};
          end
        end
        LINK_CTRL_OFS: state_next.link_ctrl = merge_word(state_reg.link_ctrl, s_axi_wdata, s_axi_wstrb);
        IRQ_STATUS_OFS: begin
          if (ro_ok) begin
            irq_set = irq_set | s_axi_wdata[IRQ_W-1:0];
          end else if (s_axi_wstrb[0]) begin
            irq_clr = s_axi_wdata[IRQ_W-1:0];
          end
        end
        IRQ_MASK_OFS: begin
          if (s_axi_wstrb[0]) begin
            state_next.irq_mask = s_axi_wdata[IRQ_W-1:0];
          end
        end
        default: wr_ok = 1'b0;
      endcase
      state_next.wr_state = SLC_WR_RESP;
      state_next.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (state_reg.wr_state == SLC_WR_RESP && s_axi_bready) begin
      state_next.wr_state = SLC_WR_IDLE;
    end

    // Set wins over clear
    state_next.irq_status = (state_reg.irq_status & ~irq_clr) | irq_set;

    // Register reads
    if (s_axi_arvalid && !state_reg.rvalid) begin
      state_next.rvalid = 1'b1;
      state_next.rdata = rd_value;
      state_next.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
endmodule

// [verification/slc_regs_sva.sv]
// Purpose: Port-level checks of the serial link config register block
// Assumes: One clock domain, reset rst_n asynchronous active low
// Notes: Bound to every slc_regs instance
`timescale 1ns/1ps
module slc_regs_sva (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire slc_pkg::slc_queue_cmd_t queue_cmd,
  input wire logic snoop_capture_en
);
  import slc_pkg::*;
  // ****************************************
  // Sequences and properties
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence flush_pulse;
    queue_cmd.flush_rx_queue ##1 !queue_cmd.flush_rx_queue;
  endsequence
  wr_resp_a: assert property (wr_taken |=> s_axi_bvalid)
    else $error("write response not one cycle after the write");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response not one cycle after the read");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before rready");
  ct_partial_a: assert property (wr_taken and s_axi_awaddr == CYCLE_TIMER_OFS && s_axi_wstrb != 4'hf
    |=> s_axi_bresp == RESP_SLVERR)
    else $error("partial timer write not refused");
  flush_self_a: assert property (wr_taken and s_axi_awaddr == QUEUE_CTRL_OFS && s_axi_wstrb[0]
    && s_axi_wdata[FLUSH_RX_BIT] |=> flush_pulse)
    else $error("receive queue flush not a single pulse");
  rx_alloc_a: assert property (queue_cmd.async_tx_alloc != 9'h000 && $stable(queue_cmd.async_tx_alloc)
    && $stable(queue_cmd.iso_tx_alloc) |-> queue_cmd.rx_alloc == QUEUE_TOTAL
    - {1'b0, queue_cmd.async_tx_alloc} - {1'b0, queue_cmd.iso_tx_alloc})
    else $error("receive allocation not the remainder");
  snoop_wr_a: assert property (wr_taken and s_axi_awaddr == DIAG_CTRL_OFS && s_axi_wstrb[0]
    |=> snoop_capture_en == $past(s_axi_wdata[SNOOP_BIT]))
    else $error("snoop enable does not follow its bit");
endmodule
bind slc_regs slc_regs_sva u_sva (.*);

// [verification/slc_host_model.sv]
// Purpose: Host side AXI4-Lite master for the config register block
// Assumes: Ready sampled between edges, handshake at the next rising edge
// Notes: Released lines other than the write strobe show the inverse of their last value
`timescale 1ns/1ps
module slc_host_model (
  input wire logic ref_clk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  // Strobe is the caller's; quadlet writes use 4'hf
  task automatic write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    logic pa, pw, ta, tw, done;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    {pa, pw, done} = 3'b110;
    while (!done) begin
      @(negedge ref_clk);
      ta = pa && s_axi_awready;
      tw = pw && s_axi_wready;
      done = !pa && !pw && s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge ref_clk);
      if (ta) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
        pa = 1'b0;
      end
      if (tw) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
        pw = 1'b0;
      end
      if (done) s_axi_bready <= 1'b0;
    end
  endtask
  task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic pa, ta, done;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    {pa, done} = 2'b10;
    while (!done) begin
      @(negedge ref_clk);
      ta = pa && s_axi_arready;
      done = !pa && s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge ref_clk);
      if (ta) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
        pa = 1'b0;
      end
      if (done) s_axi_rready <= 1'b0;
    end
  endtask
endmodule

// [verification/slc_regs_tb.sv]
// Purpose: Self-checking bench of the serial link config register block
// Assumes: Host model drives the register bus, bench drives receive words
// Notes: Timer wrap is reached by loading the last count, not by waiting
`timescale 1ns/1ps
module slc_regs_tb;
  import slc_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, snoop_capture_en, irq;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic cycle_tick = 1'b0;
  logic cycle_load = 1'b0;
  logic [31:0] cycle_load_value = 32'h0000_0000;
  slc_rx_word_t rx_word = '0;
  slc_queue_word_t rx_queue_word;
  slc_queue_cmd_t queue_cmd;
  slc_queue_word_t outq[$];
  logic [2:0] flush_seen = 3'b000;
  int n_mismatch = 0;
  int checks = 0;
  slc_regs u_dut (.*);
  slc_host_model u_host (.*);
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (rx_queue_word.valid === 1'b1) outq.push_back(rx_queue_word);
    flush_seen <= flush_seen | {queue_cmd.flush_rx_queue, queue_cmd.flush_iso_tx_queue, queue_cmd.flush_async_tx_queue};
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    u_host.write(a, d, 4'hf, r);
    chk(r, RESP_OKAY);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    u_host.read(a, d, r);
    chk(d, exp);
  endtask
  task automatic send(input logic [5:0] ch, input logic [1:0] lb, input int n);
    outq.delete();
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      rx_word <= '{valid: 1'b1, channel: ch, label: lb, last: (i == n - 1), data: 32'hd000_0000 + i};
    end
    @(posedge ref_clk);
    rx_word.valid <= 1'b0;
    rx_word.data <= ~rx_word.data;
    repeat (6) @(posedge ref_clk);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    rdchk(CYCLE_TIMER_OFS, REG_RESET);
    rdchk(ISO_RX_SEL_OFS, REG_RESET);
    rdchk(QUEUE_CTRL_OFS, REG_RESET);
    rdchk(DIAG_CTRL_OFS, REG_RESET);
    u_host.read(8'h40, d, r);
    chk(d, 32'h0000_0000);
    chk(r, RESP_SLVERR);
    $display("test reset done");
  endtask
  task automatic t_timer;
    logic [1:0] r;
    wr(CYCLE_TIMER_OFS, 32'hbfff_9f85);
    rdchk(CYCLE_TIMER_OFS, 32'hbfff_9f85);
    u_host.write(CYCLE_TIMER_OFS, 32'h0000_0000, 4'h1, r);
    chk(r, RESP_SLVERR);
    rdchk(CYCLE_TIMER_OFS, 32'hbfff_9f85);
    wr(IRQ_MASK_OFS, 32'h0000_0001);
    wr(LINK_CTRL_OFS, 32'h0000_0007);
    @(posedge ref_clk);
    cycle_tick <= 1'b1;
    @(posedge ref_clk);
    cycle_tick <= 1'b0;
    wr(LINK_CTRL_OFS, 32'h0000_0000);
    rdchk(CYCLE_TIMER_OFS, 32'h0000_0006);
    rdchk(IRQ_STATUS_OFS, 32'h0000_0001);
    chk(irq, 1'b1);
    wr(IRQ_MASK_OFS, 32'h0000_0000);
    chk(irq, 1'b0);
    wr(IRQ_MASK_OFS, 32'h0000_0001);
    wr(IRQ_STATUS_OFS, 32'h0000_0001);
    chk(irq, 1'b0);
    // Not master: an external load, then one external tick
    cycle_load_value <= 32'h0010_0080;
    wr(LINK_CTRL_OFS, 32'h0000_0005);
    @(posedge ref_clk);
    cycle_load <= 1'b1;
    @(posedge ref_clk);
    cycle_load <= 1'b0;
    cycle_tick <= 1'b1;
    @(posedge ref_clk);
    cycle_tick <= 1'b0;
    wr(LINK_CTRL_OFS, 32'h0000_0000);
    rdchk(CYCLE_TIMER_OFS, 32'h0020_0080);
    $display("test timer done");
  endtask
  task automatic t_queue;
    // Allocations sum to exactly 512, the largest legal total
    wr(QUEUE_CTRL_OFS, {9'd212, 9'd300, 9'd2, 5'b00111});
    // Let the flush monitor's update settle before looking
    @(negedge ref_clk);
    chk(flush_seen, 3'b111);
    chk(queue_cmd.rx_alloc, 10'd0);
    rdchk(QUEUE_CTRL_OFS, {9'd212, 9'd300, 9'd2, 5'b00000});
    $display("test queue done");
  endtask
  task automatic t_diag;
    wr(DIAG_CTRL_OFS, 32'hffff_ffef);
    rdchk(DIAG_CTRL_OFS, 32'h0000_0001);
    chk(snoop_capture_en, 1'b1);
    wr(DIAG_CTRL_OFS, 32'h0000_0010);
    wr(DIAG_CTRL_OFS, 32'hffff_fffe);
    rdchk(DIAG_CTRL_OFS, 32'hffff_fffe);
    chk(snoop_capture_en, 1'b0);
    wr(DIAG_CTRL_OFS, 32'h0000_0000);
    rdchk(DIAG_CTRL_OFS, 32'h0000_0000);
    $display("test diag done");
  endtask
  task automatic t_rx;
    wr(ISO_RX_SEL_OFS, 32'h0000_2415);
    wr(LINK_CTRL_OFS, 32'h0000_0008);
    send(6'h2a, 2'd0, 1);
    chk(outq.size(), 1);
    wr(LINK_CTRL_OFS, 32'h0000_0040);
    send(6'h05, 2'd0, 1);
    chk(outq.size(), 1);
    send(6'h09, 2'd0, 1);
    chk(outq.size(), 0);
    wr(LINK_CTRL_OFS, 32'h0000_0080);
    send(6'h09, 2'd0, 1);
    chk(outq.size(), 1);
    send(6'h05, 2'd0, 1);
    chk(outq.size(), 0);
    wr(ISO_RX_SEL_OFS, 32'h8000_2415);
    wr(LINK_CTRL_OFS, 32'h0000_00c0);
    send(6'h05, 2'd1, 1);
    chk(outq.size(), 1);
    send(6'h05, 2'd2, 1);
    chk(outq.size(), 0);
    wr(IRQ_STATUS_OFS, 32'h0000_0003);
    wr(LINK_CTRL_OFS, 32'h0000_0018);
    send(6'h01, 2'd0, 3);
    chk(outq.size(), 5);
    chk(outq[0].is_token, 1'b1);
    chk(outq[0].data[8:0], 9'd2);
    chk(outq[3].data[8:0], 9'd1);
    chk(outq[4].data, 32'hd000_0002);
    rdchk(IRQ_STATUS_OFS, 32'h0000_0002);
    wr(LINK_CTRL_OFS, 32'h0000_0038);
    send(6'h01, 2'd0, 3);
    chk(outq.size(), 3);
    wr(LINK_CTRL_OFS, 32'h0000_0008);
    send(6'h01, 2'd0, 3);
    chk(outq.size(), 3);
    $display("test receive done");
  endtask
  initial begin
    #200_000;
    n_mismatch++;
    results();
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_timer();
    t_queue();
    t_diag();
    t_rx();
    results();
  end
endmodule
